// ===== design/lbbp_defs.svh
// register offsets, bit positions, reset values and frame counts of the lighting link port
`ifndef LBBP_DEFS_SVH
`define LBBP_DEFS_SVH

// register byte addresses
`define LBBP_OFF_RATE 16'h0040
`define LBBP_OFF_RX_ADDR 16'h0041
`define LBBP_OFF_RX_DATA 16'h0042
`define LBBP_OFF_REPLY 16'h0043
`define LBBP_OFF_CTRL 16'h0044
`define LBBP_OFF_STAT 16'h0045

// common reset value of every register except link_status, which reads 10h
`define LBBP_RESET_VAL 8'h00

// link_control bit positions
`define LBBP_CR_EN 3
`define LBBP_CR_ACK 2
`define LBBP_CR_RTS 1
`define LBBP_CR_FORCE 0

// link_status bit positions
`define LBBP_SR_IRQ_EN 7
`define LBBP_SR_EOF 6
`define LBBP_SR_ERR 5
`define LBBP_SR_RX_STATE 4

// sample pulses that vote on a phase level, and the last pulse of a phase
`define LBBP_SMP_A 4'h6
`define LBBP_SMP_B 4'h7
`define LBBP_SMP_C 4'h8
`define LBBP_SMP_LAST 4'hF

// low phases in a row that mean a dead bus (two bit periods)
`define LBBP_FAIL_PHASES 3'h4

// phase indices: forward frame 19 bits = 38 phases, backward 11 bits = 22 phases
`define LBBP_RX_LAST_DATA 6'h21
`define LBBP_RX_LAST 6'h25
`define LBBP_TX_FIRST_STOP 6'h12
`define LBBP_TX_LAST 6'h15

`endif

// ===== design/lbbp_pkg.sv
// types shared by the lighting link port modules
`default_nettype none
package lbbp_pkg;

  // frame state machine
  typedef enum logic [1:0] {
    LBBP_S_IDLE,
    LBBP_S_RX,
    LBBP_S_WAIT,
    LBBP_S_TX
  } lbbp_state_t;

  // one register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lbbp_bus_req_t;

  // state of the sample tick generator
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } lbbp_tick_state_t;

  // state of the port
  typedef struct packed {
    lbbp_state_t state;
    logic [7:0] rate;
    logic [7:0] rx_addr;
    logic [7:0] rx_data;
    logic [7:0] reply;
    logic en;
    logic ack;
    logic rts;
    logic force_tx;
    logic irq_en;
    logic eof;
    logic err_flag;
    logic [3:0] edge_cnt;
    logic [3:0] smp_cnt;
    logic s6;
    logic s7;
    logic rx_prev;
    logic [5:0] phase_idx;
    logic first_phase;
    logic [2:0] low_run;
    logic [15:0] shift;
    logic [7:0] rdata;
    logic tx;
    logic irq;
  } lbbp_port_state_t;

endpackage
`default_nettype wire

// ===== design/lbbp_tick_gen.sv
// sample tick generator: one tick every rate_divider+1 core clocks
`default_nettype none
module lbbp_tick_gen
  import lbbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] divider,
  output logic tick
);

  lbbp_tick_state_t st_reg;
  lbbp_tick_state_t st_next;

  // sixteen ticks make one bit phase, so phase rate is clk/((N+1)*16)
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run)
    begin
      st_next.cnt = 8'h00;
    end
    else if (st_reg.cnt == divider) // RL1
    begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule
`default_nettype wire

// ===== design/lbbp_port.sv
// lighting bus bi-phase port: registers, receiver, transmitter and frame control
//
// How it works
// RL1 - phase rate is core clock over (N+1)*16, N from rate_divider
// RL2 - good forward frame loads its address byte into rx_address_byte
// RL3 - good forward frame loads its data byte into rx_data_byte
// RL4 - software writes reply_data_byte before it starts a transmission
// RL5 - link_enable gates the link; clearing it resets the frame machine
// RL6 - software acknowledges each frame; the acknowledge bit clears itself
// RL7 - transmit select picks receive or transmit for the next frame
// RL8 - force_transmit sends without a forward frame, then raises end of frame
// RL9 - software should toggle enable off and on before forcing transmit
// RL10 - irq_enable is the only writable status bit and gates the interrupt
// RL11 - end_of_frame_flag sets at frame end, clears on acknowledge
// RL12 - error_flag sets on bad format or dead bus, clears on status read
// RL13 - receive_state_flag reads one in receive state, zero in transmit
// RL14 - status low nibble captures the sample counter at each phase edge in idle or receive state
// RL15 - control bits 7:4 always read zero
// RL16 - six registers at 0040h to 0045h, all reset to 00h except link_status, which reads 10h (receive_state_flag)
// RL17 - forward frame: start one, address and data MSB first, two stops
// RL18 - backward frame: start one, reply byte MSB first, two high stops
// RL19 - sixteen samples per phase, vote of pulses 6 7 8, restart on edge
// RL20 - in receive state, bus low for two bit periods sets error flag
// RL21 - writes to read-only registers and bits change nothing
//
// Implementation choice: the strobed register port.
`include "lbbp_defs.svh"
`default_nettype none
module lbbp_port
  import lbbp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire lbbp_bus_req_t BUS_REQ,
  input wire logic RX_IN,
  output logic [7:0] RD_DATA,
  output logic TX_OUT,
  output logic IRQ
);

  lbbp_port_state_t r_reg;
  lbbp_port_state_t r_next;
  logic tick;
  logic rx_mode;
  logic phase_evt;
  logic phase_lvl;
  logic phase_end;
  logic frame_err;

  // address match, shared by write and read decode
  function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] off);
    reg_hit = (a == off);
  endfunction

  // two-of-three vote on the sample pulses
  function automatic logic vote3(input logic a, input logic b, input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  // line level for a backward frame phase: start, data pairs, high stops
  function automatic logic tx_level(input logic [5:0] idx, input logic [7:0] data);
    logic [5:0] k;
    logic bit_val;
    k = 6'h00;
    bit_val = 1'b1;
    if (idx >= `LBBP_TX_FIRST_STOP)
    begin
      tx_level = 1'b1;
    end
    else if (idx < 6'h02)
    begin
      tx_level = idx[0];
    end
    else
    begin
      k = (idx - 6'h02) >> 1;
      bit_val = data[3'h7 - k[2:0]];
      tx_level = idx[0] ? bit_val : ~bit_val;
    end
  endfunction

  // sample tick source, halted while the link is disabled
  lbbp_tick_gen u_tick (
    .clk(CORE_CLK),
    .rst(RST),
    .run(r_reg.en),
    .divider(r_reg.rate),
    .tick(tick)
  );

  // next-state logic for registers, sampler and frame machine
  always_comb
  begin
    r_next = r_reg;
    r_next.ack = 1'b0; // RL6
    r_next.rdata = 8'h00;
    r_next.rx_prev = RX_IN;
    phase_evt = 1'b0;
    phase_lvl = 1'b1;
    frame_err = 1'b0;
    rx_mode = r_reg.en && (r_reg.state == LBBP_S_IDLE || r_reg.state == LBBP_S_RX);
    phase_end = tick && (r_reg.smp_cnt == `LBBP_SMP_LAST);

    // software writes; read-only registers and bits are left alone
    if (BUS_REQ.wr)
    begin
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_RATE))
      begin
        r_next.rate = BUS_REQ.wdata;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_REPLY))
      begin
        r_next.reply = BUS_REQ.wdata;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_CTRL))
      begin
        r_next.en = BUS_REQ.wdata[`LBBP_CR_EN]; // RL5
        r_next.ack = BUS_REQ.wdata[`LBBP_CR_ACK]; // RL6
        r_next.rts = BUS_REQ.wdata[`LBBP_CR_RTS]; // RL7
        r_next.force_tx = BUS_REQ.wdata[`LBBP_CR_FORCE]; // RL8
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_STAT))
      begin
        r_next.irq_en = BUS_REQ.wdata[`LBBP_SR_IRQ_EN]; // RL10 RL21
      end
    end

    // read mux; data shows in the next cycle only
    if (BUS_REQ.rd)
    begin
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_RATE))
      begin
        r_next.rdata = r_reg.rate;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_RX_ADDR))
      begin
        r_next.rdata = r_reg.rx_addr;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_RX_DATA))
      begin
        r_next.rdata = r_reg.rx_data;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_REPLY))
      begin
        r_next.rdata = r_reg.reply;
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_CTRL))
      begin
        r_next.rdata = {4'h0, r_reg.en, r_reg.ack, r_reg.rts, r_reg.force_tx}; // RL15
      end
      if (reg_hit(BUS_REQ.addr, `LBBP_OFF_STAT))
      begin
        r_next.rdata = {r_reg.irq_en, r_reg.eof, r_reg.err_flag,
                        (r_reg.state != LBBP_S_TX), r_reg.edge_cnt}; // RL13
        r_next.err_flag = 1'b0; // RL12
      end
    end

    // acknowledge clears end of frame; a new frame end below still wins
    if (r_reg.ack)
    begin
      r_next.eof = 1'b0; // RL11
    end

    // sample counter: restarts on a phase edge while receiving
    if (rx_mode && (RX_IN != r_reg.rx_prev))
    begin
      r_next.edge_cnt = r_reg.smp_cnt; // RL14
      r_next.smp_cnt = 4'h0; // RL19
    end
    else if (tick)
    begin
      r_next.smp_cnt = r_reg.smp_cnt + 4'h1;
      if (r_reg.smp_cnt == `LBBP_SMP_A)
      begin
        r_next.s6 = RX_IN;
      end
      if (r_reg.smp_cnt == `LBBP_SMP_B)
      begin
        r_next.s7 = RX_IN;
      end
      if (r_reg.smp_cnt == `LBBP_SMP_C)
      begin
        phase_evt = rx_mode;
        phase_lvl = vote3(r_reg.s6, r_reg.s7, RX_IN); // RL19
      end
    end

    // dead bus watch: count low phases in a row while receiving
    if (phase_evt)
    begin
      if (phase_lvl)
      begin
        r_next.low_run = 3'h0;
      end
      else if (r_reg.low_run + 3'h1 >= `LBBP_FAIL_PHASES)
      begin
        r_next.low_run = 3'h0;
        frame_err = 1'b1; // RL20
      end
      else
      begin
        r_next.low_run = r_reg.low_run + 3'h1;
      end
    end

    // frame machine
    case (r_reg.state)
      LBBP_S_IDLE:
      begin
        if (r_reg.force_tx)
        begin
          r_next.state = LBBP_S_TX; // RL8
          r_next.phase_idx = 6'h00;
          r_next.smp_cnt = 4'h0;
        end
        else if (phase_evt && !phase_lvl && !frame_err)
        begin
          r_next.state = LBBP_S_RX; // RL17
          r_next.phase_idx = 6'h01;
          r_next.first_phase = 1'b0;
        end
      end
      LBBP_S_RX:
      begin
        if (phase_evt)
        begin
          r_next.phase_idx = r_reg.phase_idx + 6'h01;
          if (r_reg.phase_idx <= `LBBP_RX_LAST_DATA)
          begin
            if (!r_reg.phase_idx[0])
            begin
              r_next.first_phase = phase_lvl;
            end
            else if (phase_lvl == r_reg.first_phase)
            begin
              frame_err = 1'b1; // RL12
            end
            else if (r_reg.phase_idx != 6'h01)
            begin
              r_next.shift = {r_reg.shift[14:0], phase_lvl}; // RL17
            end
          end
          else if (!phase_lvl)
          begin
            frame_err = 1'b1; // RL12
          end
          else if (r_reg.phase_idx == `LBBP_RX_LAST)
          begin
            r_next.rx_addr = r_reg.shift[15:8]; // RL2
            r_next.rx_data = r_reg.shift[7:0]; // RL3
            r_next.eof = 1'b1; // RL11
            r_next.state = LBBP_S_WAIT;
          end
        end
      end
      LBBP_S_WAIT:
      begin
        if (r_reg.ack)
        begin
          r_next.phase_idx = 6'h00;
          r_next.low_run = 3'h0;
          if (r_reg.rts || r_reg.force_tx)
          begin
            r_next.state = LBBP_S_TX; // RL7
            r_next.smp_cnt = 4'h0;
          end
          else
          begin
            r_next.state = LBBP_S_IDLE; // RL7
          end
        end
      end
      LBBP_S_TX:
      begin
        if (phase_end)
        begin
          r_next.phase_idx = r_reg.phase_idx + 6'h01;
          if (r_reg.phase_idx == `LBBP_TX_LAST)
          begin
            r_next.phase_idx = 6'h00;
            r_next.eof = 1'b1; // RL11 RL8
            r_next.state = LBBP_S_WAIT;
          end
        end
      end
      default:
      begin
        r_next.state = LBBP_S_IDLE;
      end
    endcase

    // a bad frame is dropped and the machine hunts for a new start bit
    if (frame_err)
    begin
      r_next.err_flag = 1'b1; // RL12
      r_next.state = LBBP_S_IDLE;
      r_next.phase_idx = 6'h00;
    end

    // disabled link holds the whole frame machine in its reset state
    if (!r_reg.en)
    begin
      r_next.state = LBBP_S_IDLE; // RL5
      r_next.phase_idx = 6'h00;
      r_next.low_run = 3'h0;
      r_next.smp_cnt = 4'h0;
      r_next.shift = 16'h0000;
    end

    // line drive and interrupt, both registered
    if (r_next.state == LBBP_S_TX)
    begin
      r_next.tx = tx_level(r_next.phase_idx, r_reg.reply); // RL18 RL4
    end
    else
    begin
      r_next.tx = 1'b1;
    end
    r_next.irq = r_next.irq_en & r_next.eof; // RL10
  end

  // state register; line idles high through reset
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      r_reg <= '0; // RL16
      r_reg.tx <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flip-flops
  assign RD_DATA = r_reg.rdata;
  assign TX_OUT = r_reg.tx;
  assign IRQ = r_reg.irq;

endmodule
`default_nettype wire

// ===== dv/lbbp_port_checker.sv
// checker for the lighting link port pins and register bus
`default_nettype none
module lbbp_port_checker
  import lbbp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire lbbp_bus_req_t BUS_REQ,
  input wire logic RX_IN,
  input wire logic [7:0] RD_DATA,
  input wire logic TX_OUT,
  input wire logic IRQ
);
  logic [7:0] rate_q;
  logic [13:0] low_cnt;
  logic sw_st;
  logic sw_ct;
  // shadow of rate_divider and length of the current low run on the line
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      rate_q <= 8'h00;
      low_cnt <= 14'h0000;
    end
    else
    begin
      if (BUS_REQ.wr && BUS_REQ.addr == 16'h0040)
        rate_q <= BUS_REQ.wdata;
      low_cnt <= TX_OUT ? 14'h0000 : low_cnt + 14'h0001;
    end
  end
  // writes to status and control
  assign sw_st = BUS_REQ.wr && BUS_REQ.addr == 16'h0045;
  assign sw_ct = BUS_REQ.wr && BUS_REQ.addr == 16'h0044;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  a_reset_quiet: assert property (disable iff (1'b0)
    RST |=> TX_OUT && !IRQ && RD_DATA == 8'h00) else $error("outputs busy after reset");
  a_read_quiet: assert property (!BUS_REQ.rd |=> RD_DATA == 8'h00)
    else $error("read data outside a read");
  a_ctrl_reserved: assert property (BUS_REQ.rd && BUS_REQ.addr == 16'h0044
    |=> RD_DATA[7:4] == 4'h0) else $error("control upper bits set");
  a_irq_masked: assert property (sw_st && !BUS_REQ.wdata[7] ##1 !sw_st |=> !IRQ)
    else $error("interrupt while masked");
  a_ack_clears: assert property (sw_ct && BUS_REQ.wdata[2] && !BUS_REQ.wdata[0]
    |-> ##3 !IRQ) else $error("end of frame kept after acknowledge");
  a_flag_holds: assert property (IRQ && !BUS_REQ.wr && !$past(BUS_REQ.wr)
    && !$past(BUS_REQ.wr, 2) |=> IRQ) else $error("end of frame lost without acknowledge");
  a_tx_state_flag: assert property (BUS_REQ.rd && BUS_REQ.addr == 16'h0045 && !TX_OUT
    |=> !RD_DATA[4]) else $error("receive flag set while sending");
  a_disable_idle: assert property (sw_ct && !BUS_REQ.wdata[3] |-> ##2 TX_OUT)
    else $error("line driven while disabled");
  a_phase_width: assert property ($rose(TX_OUT) |-> low_cnt == 16 * (rate_q + 1)
    || low_cnt == 32 * (rate_q + 1)) else $error("low phase length wrong");
endmodule
`default_nettype wire

// ===== dv/lbbp_net_model.sv
// network master model: sends bi-phase forward frames, decodes backward frames
`default_nettype none
module lbbp_net_model
(
  input wire logic clk,
  input wire logic send,
  input wire logic low_hold,
  input wire logic [15:0] word,
  input wire logic tx_in,
  output logic line,
  output logic [7:0] back
);
  timeunit 1ns;
  timeprecision 1ps;
  logic b;
  // forward frame: start one, 16 bits msb first, then idle high (pull-up level)
  always @(posedge clk)
  begin
    if (send)
    begin
      for (int i = 16; i >= 0; i--)
      begin
        b = (i == 16) || word[i[3:0]];
        line <= ~b;
        repeat (16) @(posedge clk);
        line <= b;
        repeat (16) @(posedge clk);
      end
    end
    line <= ~low_hold;
  end
  // backward frame: second half of each data bit, assumes 16 clocks a phase
  always @(negedge tx_in)
  begin
    repeat (56) @(posedge clk);
    for (int j = 7; j >= 0; j--)
    begin
      back[j] <= tx_in;
      repeat (32) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the lighting link port
`default_nettype none
module testbench
  import lbbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lbbp_bus_req_t req = '0;
  logic rx, tx, irq, send = 1'b0, hold = 1'b0;
  logic [7:0] rdd, back, v, r;
  logic [15:0] word = 16'h0000;
  logic [31:0] seed = 32'h00000054;
  int err_total = 0, total_checks = 0, n, m;
  always #4 clk = ~clk;
  lbbp_port dut (.CORE_CLK(clk), .RST(rst), .BUS_REQ(req), .RX_IN(rx), .RD_DATA(rdd),
    .TX_OUT(tx), .IRQ(irq));
  lbbp_net_model net (.clk(clk), .send(send), .low_hold(hold), .word(word), .tx_in(tx),
    .line(rx), .back(back));
  // xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // value a register reads back after a write of d
  function automatic logic [7:0] rw_exp(input int a, input logic [7:0] d);
    case (a)
      64, 67: return d;
      68: return d & 8'h02;
      69: return (d & 8'h80) | 8'h10;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // one bus access, write when w, else read; read data taken in the following cycle
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w,
    output logic [7:0] o);
    req <= '{a, d, w, ~w};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    o = rdd;
  endtask
  // bounded wait for the interrupt (s) or the line (not s) to reach a level
  task automatic till(input logic s, input logic want, input int lim);
    while ((s ? irq : tx) !== want && lim > 0)
    begin
      @(posedge clk);
      lim--;
    end
    chk({7'h00, s ? irq : tx}, {7'h00, want}, "wait");
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200000;
    err_total++;
    summarize();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 64; i < 71; i++)
    begin
      acc(i[15:0], 8'h00, 1'b0, v);
      chk(v & (i == 69 ? 8'hEF : 8'hFF), 8'h00, "reset");
    end
    $display("end reset values");
    for (int i = 64; i < 70; i++)
    begin
      r = 8'(xs());
      r = (i == 68) ? r & 8'hF2 : r;
      acc(i[15:0], r, 1'b1, v);
      acc(i[15:0], 8'h00, 1'b0, v);
      chk(v, rw_exp(i, r), "readback");
    end
    $display("end access kinds");
    acc(16'h0040, 8'h00, 1'b1, v);
    acc(16'h0045, 8'h80, 1'b1, v);
    acc(16'h0044, 8'h08, 1'b1, v);
    word <= 16'(xs());
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    till(1'b1, 1'b1, 900);
    acc(16'h0041, 8'h00, 1'b0, v);
    chk(v, word[15:8], "address");
    acc(16'h0042, 8'h00, 1'b0, v);
    chk(v, word[7:0], "data");
    acc(16'h0045, 8'h00, 1'b0, v);
    chk(v, 8'hDF, "status");
    r = 8'(xs());
    acc(16'h0043, r, 1'b1, v);
    acc(16'h0044, 8'h0E, 1'b1, v);
    till(1'b0, 1'b0, 40);
    acc(16'h0045, 8'h00, 1'b0, v);
    chk(v & 8'h50, 8'h00, "sending");
    till(1'b1, 1'b1, 500);
    chk(back, r, "reply");
    $display("end receive and reply");
    acc(16'h0044, 8'h0C, 1'b1, v);
    hold <= 1'b1;
    repeat (100) @(posedge clk);
    hold <= 1'b0;
    repeat (40) @(posedge clk);
    acc(16'h0045, 8'h00, 1'b0, v);
    chk(v & 8'h60, 8'h20, "error");
    acc(16'h0045, 8'h00, 1'b0, v);
    chk(v & 8'h20, 8'h00, "error cleared");
    $display("end dead bus");
    r = 8'(xs());
    acc(16'h0044, 8'h00, 1'b1, v);
    acc(16'h0043, r, 1'b1, v);
    acc(16'h0044, 8'h09, 1'b1, v);
    till(1'b1, 1'b1, 500);
    chk(back, r, "forced");
    n = 1 + int'(xs() % 3);
    acc(16'h0044, 8'h04, 1'b1, v);
    acc(16'h0040, n[7:0], 1'b1, v);
    acc(16'h0044, 8'h09, 1'b1, v);
    till(1'b0, 1'b0, 200);
    m = 0;
    while (tx === 1'b0 && m < 300)
    begin
      @(posedge clk);
      m++;
    end
    chk(m[7:0], 8'(16 * (n + 1)), "phase");
    till(1'b1, 1'b1, 2000);
    acc(16'h0045, 8'h00, 1'b1, v);
    @(posedge clk);
    chk({7'h00, irq}, 8'h00, "masked");
    acc(16'h0044, 8'h0C, 1'b1, v);
    $display("end forced transmit");
    summarize();
  end
endmodule
bind lbbp_port lbbp_port_checker chk_i (.CORE_CLK(CORE_CLK), .RST(RST), .BUS_REQ(BUS_REQ),
  .RX_IN(RX_IN), .RD_DATA(RD_DATA), .TX_OUT(TX_OUT), .IRQ(IRQ));
`default_nettype wire
